// ### pcscsu_params.svh
// constants for the pcs configuration upper bank: offsets, fields, reset values, timing
`ifndef PCSCSU_PARAMS_SVH
`define PCSCSU_PARAMS_SVH

// ----------------------------------------------------------------
// register placement
// ----------------------------------------------------------------
`define PCSCSU_ADDR_W          12
`define PCSCSU_REG_INDEX       12'h016
`define PCSCSU_REG_ADDR        (`PCSCSU_REG_INDEX << 2)
`define PCSCSU_FIELD_LSB       6
`define PCSCSU_FIELD_W         10
`define PCSCSU_LOW_W           6
`define PCSCSU_HIGH_W          16

// ----------------------------------------------------------------
// field positions inside the 16-bit register
// ----------------------------------------------------------------
`define PCSCSU_BIT_XOVER       15
`define PCSCSU_BIT_FREE_CLK    11
`define PCSCSU_BIT_QUIET       10
`define PCSCSU_BIT_SD_FORCE    9
`define PCSCSU_BIT_SD_HOLD     8
`define PCSCSU_BIT_DESC_LONG   7
`define PCSCSU_BIT_FIBER       6

// ----------------------------------------------------------------
// reset value of bits 15:6, fiber bit added from the strap later
// ----------------------------------------------------------------
`define PCSCSU_CFG_RESET       10'h004

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCSCSU_CLK_PERIOD_NS   40
`define PCSCSU_DESC_SHORT_NS   722000
`define PCSCSU_DESC_LONG_NS    2000000
`define PCSCSU_XOVER_NS        1000000
`define PCSCSU_DESC_SHORT_CYC  (`PCSCSU_DESC_SHORT_NS / `PCSCSU_CLK_PERIOD_NS)
`define PCSCSU_DESC_LONG_CYC   (`PCSCSU_DESC_LONG_NS / `PCSCSU_CLK_PERIOD_NS)
`define PCSCSU_XOVER_CYC       (`PCSCSU_XOVER_NS / `PCSCSU_CLK_PERIOD_NS)
`define PCSCSU_CNT_W           16
`define PCSCSU_STRAP_SETTLE    2'h3

`endif

// ### pcscsu_pkg.sv
// types shared by the pcs configuration upper bank
package pcscsu_pkg;

    // ----------------------------------------------------------------
    // bits 15:6 of the register, msb first
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       xover;
        logic [2:0] reserved;
        logic       free_clk;
        logic       quiet_transmit_en;
        logic       signal_detect_force;
        logic       signal_detect_link_hold;
        logic       descrambler_timeout_sel;
        logic       fiber_mode_en;
    } pcscsu_cfg_s;

    // ----------------------------------------------------------------
    // raw receive-side status from the pma and descrambler, plus the fiber strap
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signal_valid;
        logic descrambler_lock;
        logic idle_toggle;
        logic fiber_strap;
    } pcscsu_line_s;

    typedef enum logic [1:0] {
        PCSCSU_LINK_DOWN = 2'b01,
        PCSCSU_LINK_UP   = 2'b10
    } pcscsu_link_e;

endpackage : pcscsu_pkg

// ### pcscsu_sync.sv
// three-stage synchroniser with agreement filter, one per bit
module pcscsu_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    // ----------------------------------------------------------------
    // per-bit chain
    // ----------------------------------------------------------------
    // stage one feeds stage two only; the filter looks at stages two and three
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1      <= 1'b0;
                s2      <= 1'b0;
                s3      <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1 <= din[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    dout[i] <= s3;
                end
            end
        end
    end

endmodule : pcscsu_sync

// ### pcscsu_top.sv
// pcs configuration bank, bits 15:6, with apb access and the link logic it steers
`include "pcscsu_params.svh"
module pcscsu_top
    import pcscsu_pkg::*;
#(
    parameter int unsigned DESC_SHORT_CYCLES = `PCSCSU_DESC_SHORT_CYC,
    parameter int unsigned DESC_LONG_CYCLES  = `PCSCSU_DESC_LONG_CYC,
    parameter int unsigned XOVER_CYCLES      = `PCSCSU_XOVER_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`PCSCSU_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire pcscsu_pkg::pcscsu_line_s   line_in,
    input  wire logic                       autoneg_en,
    input  wire logic                       auto_pair_swap_en,
    output logic                            mdix_sel,
    output logic                            rx_clk_free_run,
    output logic                            quiet_transmit,
    output logic                            signal_detect,
    output logic                            link_up,
    output logic                            descrambler_timeout,
    output logic                            fiber_mode
);
    import pcscsu_pkg::*;

    // ----------------------------------------------------------------
    // synchronised line status
    // ----------------------------------------------------------------
    pcscsu_line_s line_s;

    pcscsu_sync #(
        .WIDTH ($bits(pcscsu_line_s))
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (line_in),
        .dout    (line_s)
    );

    // ----------------------------------------------------------------
    // strap capture: the bus waits until the strap has settled
    // ----------------------------------------------------------------
    logic [1:0] settle_cnt;
    logic       strap_arm;
    logic       strap_done;

    wire settle_last = (settle_cnt == `PCSCSU_STRAP_SETTLE);

    // the synchroniser only carries the strap from the fourth edge on, so the load waits one edge more
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 2'h0;
            strap_arm  <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            settle_cnt <= settle_cnt + 2'h1;
            strap_arm  <= strap_arm || settle_last;
            strap_done <= strap_arm;
        end
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    pcscsu_cfg_s cfg;
    pcscsu_cfg_s next_cfg;

    wire hit      = (paddr == `PCSCSU_REG_ADDR);
    wire access   = psel && penable && pready;
    wire wr_hit   = access && pwrite && hit;
    wire [15:0] rd_word  = {next_cfg, {`PCSCSU_LOW_W{1'b0}}};

    assign pready  = strap_done;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        next_cfg = cfg;
        if (wr_hit) begin
            next_cfg = pwdata[`PCSCSU_HIGH_W-1:`PCSCSU_FIELD_LSB];
        end
        if (strap_arm && !strap_done) begin
            next_cfg.fiber_mode_en = line_s.fiber_strap;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `PCSCSU_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && (!penable || !pready)) begin
            // reloaded while waiting, so a read that spans the strap load returns the loaded bit
            prdata <= (hit && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // static controls and signal detect
    // ----------------------------------------------------------------
    assign rx_clk_free_run = cfg.free_clk;
    assign quiet_transmit  = cfg.quiet_transmit_en;
    assign fiber_mode      = cfg.fiber_mode_en;
    assign signal_detect   = cfg.signal_detect_force || line_s.signal_valid;

    // ----------------------------------------------------------------
    // link state
    // ----------------------------------------------------------------
    pcscsu_link_e link_state;
    pcscsu_link_e next_link_state;

    wire lock     = line_s.descrambler_lock;
    wire lose_up  = !signal_detect || (!cfg.signal_detect_link_hold && !lock);

    always_comb begin
        case (link_state)
            PCSCSU_LINK_DOWN: begin
                next_link_state = (signal_detect && lock) ? PCSCSU_LINK_UP : PCSCSU_LINK_DOWN;
            end
            PCSCSU_LINK_UP: begin
                next_link_state = lose_up ? PCSCSU_LINK_DOWN : PCSCSU_LINK_UP;
            end
            default: begin
                next_link_state = PCSCSU_LINK_DOWN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_state <= PCSCSU_LINK_DOWN;
        end else begin
            link_state <= next_link_state;
        end
    end

    assign link_up = (link_state == PCSCSU_LINK_UP);

    // ----------------------------------------------------------------
    // descrambler timeout
    // ----------------------------------------------------------------
    // idle arrives as a toggle so no event is lost across the crossing
    localparam logic [`PCSCSU_CNT_W-1:0] DESC_SHORT_L = `PCSCSU_CNT_W'(DESC_SHORT_CYCLES - 1);
    localparam logic [`PCSCSU_CNT_W-1:0] DESC_LONG_L  = `PCSCSU_CNT_W'(DESC_LONG_CYCLES - 1);

    logic                     idle_last;
    logic [`PCSCSU_CNT_W-1:0] desc_cnt;

    wire idle_evt  = (line_s.idle_toggle != idle_last);
    wire [`PCSCSU_CNT_W-1:0] desc_limit = cfg.descrambler_timeout_sel ? DESC_LONG_L : DESC_SHORT_L;
    wire desc_expire = lock && !idle_evt && (desc_cnt >= desc_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_last           <= 1'b0;
            desc_cnt            <= '0;
            descrambler_timeout <= 1'b0;
        end else begin
            idle_last           <= line_s.idle_toggle;
            descrambler_timeout <= desc_expire;
            if (!lock || idle_evt || desc_expire) begin
                desc_cnt <= '0;
            end else begin
                desc_cnt <= desc_cnt + `PCSCSU_CNT_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // forced-mode crossover
    // ----------------------------------------------------------------
    // software must keep autoneg and pair swap off; we also refuse to hunt if it does not
    localparam logic [`PCSCSU_CNT_W-1:0] XOVER_L = `PCSCSU_CNT_W'(XOVER_CYCLES - 1);

    logic [`PCSCSU_CNT_W-1:0] xover_cnt;

    wire xover_active = cfg.xover && !autoneg_en && !auto_pair_swap_en && !link_up;
    wire xover_step   = xover_active && (xover_cnt == XOVER_L);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_cnt <= '0;
            mdix_sel  <= 1'b0;
        end else begin
            xover_cnt <= (!xover_active || xover_step) ? '0 : xover_cnt + `PCSCSU_CNT_W'(1);
            if (!cfg.xover) begin
                mdix_sel <= 1'b0;
            end else if (xover_step) begin
                mdix_sel <= !mdix_sel;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    link_rise_a: assert property (!link_up && signal_detect && lock |=> link_up)
        else $error("link did not come up on signal and lock");

    hold_keep_a: assert property (link_up && cfg.signal_detect_link_hold && signal_detect && !lock |=> link_up)
        else $error("link dropped on lock loss with hold set");

    lock_drop_a: assert property (link_up && !cfg.signal_detect_link_hold && !lock |=> !link_up)
        else $error("link stayed up after lock loss without hold");

    sd_force_a: assert property (wr_hit && pwdata[`PCSCSU_BIT_SD_FORCE] |=> signal_detect [*3])
        else $error("forced signal detect not reported");

    quiet_wr_a: assert property (wr_hit |=> quiet_transmit == $past(pwdata[`PCSCSU_BIT_QUIET]))
        else $error("quiet transmit does not follow write");

    free_clk_a: assert property (wr_hit |=> rx_clk_free_run == $past(pwdata[`PCSCSU_BIT_FREE_CLK]))
        else $error("rx clock mode does not follow write");

    fiber_wr_a: assert property (wr_hit |=> fiber_mode == $past(pwdata[`PCSCSU_BIT_FIBER]))
        else $error("fiber mode does not follow write");

    strap_load_a: assert property ($rose(strap_done) |-> fiber_mode == $past(line_s.fiber_strap))
        else $error("fiber enable not loaded from strap");

    timeout_len_a: assert property ($rose(descrambler_timeout) |-> $past(desc_cnt) == $past(desc_limit))
        else $error("descrambler timeout at wrong count");

    xover_idle_a: assert property (!xover_active && cfg.xover |=> $stable(mdix_sel))
        else $error("pair assignment changed while not hunting");

    rsvd_rd_a: assert property (psel && !penable && hit && !pwrite |=> prdata[5:0] == 6'h00)
        else $error("low bits not zero on read");

    link_up_c: cover property (!link_up ##1 link_up);
    hold_c:    cover property (link_up && cfg.signal_detect_link_hold && !lock ##1 link_up);
    timeout_c: cover property (descrambler_timeout);
    xover_c:   cover property (xover_step ##1 mdix_sel);

endmodule : pcscsu_top

// ### pcscsu_top_tb.sv
// self-checking bench for the pcs configuration upper bank
`include "pcscsu_params.svh"
module pcscsu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcscsu_pkg::*;

    // ----------------------------------------------------------------
    // shortened counts, expectations derive from these
    // ----------------------------------------------------------------
    localparam int          SHORT = 20;
    localparam int          LONG  = 40;
    localparam int          XOV   = 8;
    localparam logic [11:0] REG_A = 12'(`PCSCSU_REG_ADDR);
    localparam logic [31:0] RST_V = 32'(`PCSCSU_CFG_RESET) << `PCSCSU_FIELD_LSB;

    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    pcscsu_line_s line_in;
    logic         autoneg_en;
    logic         auto_pair_swap_en;
    logic         mdix_sel;
    logic         rx_clk_free_run;
    logic         quiet_transmit;
    logic         signal_detect;
    logic         link_up;
    logic         descrambler_timeout;
    logic         fiber_mode;
    int           mismatches;
    int           checks_done;

    pcscsu_top #(
        .DESC_SHORT_CYCLES (SHORT),
        .DESC_LONG_CYCLES  (LONG),
        .XOVER_CYCLES      (XOV)
    ) i_pcscsu_top (.*);

    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // one apb transfer; released once pready is seen high, or after 50 edges of waiting without it
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // the extra edge keeps a following call from driving psel twice in one step
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
        chk(32'(err), 32'(e));
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk(32'(err), 32'(e));
    endtask : rd_chk

    task automatic do_reset(input logic strap);
        line_in.fiber_strap <= strap;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    task automatic wait_link(input logic e);
        int n;
        n = 0;
        while (link_up !== e && n < 12) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(link_up), 32'(e));
    endtask : wait_link

    function automatic logic ev(input bit mx, input logic p);
        return mx ? (mdix_sel !== p) : (descrambler_timeout === 1'b1);
    endfunction : ev

    // edges between two successive events; 200 means none seen
    task automatic gap(input bit mx, output int g);
        logic p;
        p = mdix_sel;
        g = 0;
        repeat (2) begin
            g = 0;
            do begin
                @(posedge pclk);
                g++;
            end while (!ev(mx, p) && g < 200);
            p = mdix_sel;
        end
    endtask : gap

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        int          g;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        line_in = '0;
        autoneg_en = 1'b0;
        auto_pair_swap_en = 1'b0;
        mismatches = 0;
        checks_done = 0;
        do_reset(1'b1);
        rd_chk(REG_A, RST_V | 32'h40, 1'b0);
        chk(32'({rx_clk_free_run, quiet_transmit, fiber_mode}), 32'h1);
        do_reset(1'b0);
        rd_chk(REG_A, RST_V, 1'b0);
        wr(REG_A, 32'hffff_ffff, 1'b0);
        rd_chk(REG_A, 32'h0000_ffc0, 1'b0);
        wr(12'h05c, 32'h0000_0000, 1'b1);
        rd_chk(12'h05c, 32'h0, 1'b1);
        rd_chk(REG_A, 32'h0000_ffc0, 1'b0);
        for (int b = 6; b < 16; b++) begin
            v = 32'h1 << b;
            wr(REG_A, v, 1'b0);
            rd_chk(REG_A, v, 1'b0);
            chk(32'({rx_clk_free_run, quiet_transmit, signal_detect, fiber_mode}),
                32'({v[11], v[10], v[9], v[6]}));
        end
        wr(REG_A, 32'h8100, 1'b0);
        gap(1'b1, g);
        chk(32'(g), 32'(XOV));
        autoneg_en <= 1'b1;
        gap(1'b1, g);
        chk(32'(g), 32'd200);
        autoneg_en <= 1'b0;
        auto_pair_swap_en <= 1'b1;
        gap(1'b1, g);
        chk(32'(g), 32'd200);
        auto_pair_swap_en <= 1'b0;
        wr(REG_A, 32'h0100, 1'b0);
        chk(32'(mdix_sel), 32'h0);
        line_in.signal_valid <= 1'b1;
        line_in.descrambler_lock <= 1'b1;
        wait_link(1'b1);
        gap(1'b0, g);
        chk(32'(g), 32'(SHORT));
        wr(REG_A, 32'h0180, 1'b0);
        gap(1'b0, g);
        chk(32'(g), 32'(LONG));
        // idle events every 8 edges keep restarting the count, so no timeout may fire
        g = 0;
        for (int k = 0; k < 12; k++) begin
            line_in.idle_toggle <= ~line_in.idle_toggle;
            repeat (8) begin
                @(posedge pclk);
                if (descrambler_timeout === 1'b1) begin
                    g++;
                end
            end
        end
        chk(32'(g), 32'h0);
        line_in.descrambler_lock <= 1'b0;
        // lock loss must not drop the link while the hold option is set
        repeat (12) @(posedge pclk);
        chk(32'(link_up), 32'h1);
        line_in.signal_valid <= 1'b0;
        wait_link(1'b0);
        wr(REG_A, 32'h0000, 1'b0);
        line_in.signal_valid <= 1'b1;
        line_in.descrambler_lock <= 1'b1;
        wait_link(1'b1);
        line_in.descrambler_lock <= 1'b0;
        wait_link(1'b0);
        wr(REG_A, 32'h0000_0040, 1'b0);
        chk(32'(fiber_mode), 32'h1);
        // a full reset stands in for the soft reset that software issues after a fiber change
        do_reset(1'b0);
        rd_chk(REG_A, RST_V, 1'b0);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        final_report();
    end

endmodule : pcscsu_top_tb
